// File: hdl/timeslot_loop_switch_delay.sv
// Time-slot switch core with loop routing, tristate field and frame-delay data memory
`timescale 1ns/1ps
module timeslot_loop_switch_delay
    import tsloop_pkg::*;
#(
    parameter int SLOTS = NUM_SLOTS
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic frame_sync,
    input wire logic pcm_rx,
    input wire logic cfi_rx,
    input wire host_cmd_s host_cmd,
    input wire logic host_cmd_stb,
    output logic pcm_tx,
    output logic pcm_tx_oe,
    output logic cfi_tx,
    output logic cfi_tx_oe,
    output logic [SLOT_W-1:0] slot_index,
    output logic cmd_done
);

    // Pin synchronisers, first stage read only by the second
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
        end
        else
        begin
            sync1_reg <= {frame_sync, pcm_rx, cfi_rx};
            sync2_reg <= sync1_reg;
        end
    end
    logic fs_s, pcm_s, cfi_s;
    assign fs_s = sync2_reg[2];
    assign pcm_s = sync2_reg[1];
    assign cfi_s = sync2_reg[0];

    // Decode of a slot pointer into a memory index
    function automatic logic [SLOT_W-1:0] slot_of(input logic [7:0] v);
        slot_of = v[SLOT_W-1:0];
    endfunction

    // Storage: two control memories, two data memories, tristate field
    cm_entry_s cm_up_reg [SLOTS];
    cm_entry_s cm_dn_reg [SLOTS];
    logic [7:0] dm_up_reg [SLOTS];
    logic [7:0] dm_dn_reg [SLOTS];
    logic [3:0] tri_reg [SLOTS];

    // Frame and bit timing
    logic [BIT_CNT_W-1:0] bit_reg, bit_next;
    logic [SLOT_W-1:0] slot_reg, slot_next;
    phase_e phase_reg, phase_next;
    logic fs_d_reg;
    always_comb
    begin
        bit_next = bit_reg + 3'h1;
        slot_next = slot_reg;
        if (bit_reg == LAST_BIT)
            slot_next = slot_reg + 5'h01;
        if (fs_s && !fs_d_reg)
        begin
            bit_next = 3'h0;
            slot_next = 5'h00;
        end
        case (bit_next)
            WR_WINDOW: phase_next = PH_WRITE;
            RD_WINDOW: phase_next = PH_READ;
            default: phase_next = PH_IDLE;
        endcase
    end
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            bit_reg <= 3'h0;
            slot_reg <= 5'h00;
            phase_reg <= PH_IDLE;
            fs_d_reg <= 1'b0;
        end
        else
        begin
            bit_reg <= bit_next;
            slot_reg <= slot_next;
            phase_reg <= phase_next;
            fs_d_reg <= fs_s;
        end
    end

    // Serial to parallel on both receive sides
    logic [7:0] pcm_sr_reg, pcm_sr_next, up_sr_reg, up_sr_next;
    logic loop_in;
    logic cfi_tx_raw;
    cm_entry_s up_ent;
    cm_entry_s up_in_ent;
    assign up_ent = cm_up_reg[slot_reg];
    // Bit being shifted in belongs to the slot being entered, not the one left
    assign up_in_ent = cm_up_reg[slot_next];
    always_comb
    begin
        // leading-0 pointer loops internal downstream output upstream
        loop_in = up_in_ent.dir ? cfi_s : cfi_tx_raw;
        pcm_sr_next = {pcm_sr_reg[6:0], pcm_s};
        up_sr_next = {up_sr_reg[6:0], loop_in};
    end
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pcm_sr_reg <= 8'h00;
            up_sr_reg <= 8'h00;
        end
        else
        begin
            pcm_sr_reg <= pcm_sr_next;
            up_sr_reg <= up_sr_next;
        end
    end

    // Parallel to serial on both transmit sides
    logic [7:0] pcm_out_reg, pcm_out_next, cfi_out_reg, cfi_out_next;
    logic pcm_tx_next, pcm_oe_next, cfi_tx_next, cfi_oe_next;
    cm_entry_s dn_ent;
    logic [SLOT_W-1:0] rd_slot;
    assign dn_ent = cm_dn_reg[slot_next];
    assign rd_slot = slot_next;
    // Loop taps the bit about to be launched so it lines up with the pin samples
    assign cfi_tx_raw = cfi_out_next[LAST_BIT];
    always_comb
    begin
        pcm_out_next = {pcm_out_reg[6:0], 1'b0};
        cfi_out_next = {cfi_out_reg[6:0], 1'b0};
        // read after write sees this frame; before sees last frame
        if (phase_next == PH_READ)
        begin
            pcm_out_next = dm_up_reg[rd_slot];
            // upstream pointer reads upstream memory; index same
            if (dn_ent.dir)
                cfi_out_next = dm_up_reg[dn_ent.slot];
            else
                cfi_out_next = dm_dn_reg[dn_ent.slot];
        end
        pcm_tx_next = pcm_out_next[LAST_BIT];
        cfi_tx_next = cfi_out_next[LAST_BIT];
        // bit-pair tristate field
        // MSB leaves first, so bit period 0 uses the top pair flag
        pcm_oe_next = tri_reg[rd_slot][~bit_next[2:1]];
        // code 0000 keeps interface output disabled
        cfi_oe_next = (dn_ent.code != CC_UNASSIGNED);
    end
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pcm_out_reg <= 8'h00;
            cfi_out_reg <= 8'h00;
            pcm_tx <= 1'b0;
            pcm_tx_oe <= 1'b0;
            cfi_tx <= 1'b0;
            cfi_tx_oe <= 1'b0;
            slot_index <= 5'h00;
        end
        else
        begin
            pcm_out_reg <= pcm_out_next;
            cfi_out_reg <= cfi_out_next;
            pcm_tx <= pcm_tx_next;
            pcm_tx_oe <= pcm_oe_next;
            cfi_tx <= cfi_tx_next;
            cfi_tx_oe <= cfi_oe_next;
            slot_index <= slot_reg;
        end
    end

    // Host command decode; host_cmd_stb executes the command in the control byte
    logic is_tri, is_conn, up_sel, done_next;
    cm_entry_s new_ent;
    always_comb
    begin
        is_tri = host_cmd_stb && (host_cmd.ctrl == CMD_TRISTATE);
        // connection command 0111 cccc, codes up to 0111
        is_conn = host_cmd_stb && (host_cmd.ctrl[7:4] == CMD_CONN_HI) && (host_cmd.ctrl[3:0] <= CC_MAX);
        // address direction bit picks upstream memory
        up_sel = host_cmd.addr[DIR_BIT];
        new_ent.dir = host_cmd.data[DIR_BIT];
        new_ent.slot = slot_of(host_cmd.data);
        new_ent.code = host_cmd.ctrl[3:0];
        done_next = is_tri || is_conn;
    end

    // Memory writes: data memories only in the write window
    genvar gi;
    generate
        for (gi = 0; gi < SLOTS; gi++)
        begin : g_mem
            always_ff @(posedge clk)
            begin
                if (sys_rst)
                begin
                    cm_up_reg[gi] <= '0;
                    cm_dn_reg[gi] <= '0;
                    tri_reg[gi] <= TRI_ALL_HIGH_Z[3:0];
                    dm_up_reg[gi] <= 8'h00;
                    dm_dn_reg[gi] <= 8'h00;
                end
                else
                begin
                    if (is_conn && slot_of(host_cmd.addr) == gi && up_sel)
                        cm_up_reg[gi] <= new_ent;
                    if (is_conn && slot_of(host_cmd.addr) == gi && !up_sel)
                        cm_dn_reg[gi] <= new_ent;
                    if (is_tri && slot_of(host_cmd.addr) == gi)
                        tri_reg[gi] <= host_cmd.data[3:0];
                    // write in window; single frame storage
                    // Shift register holds the whole slot while bit 7 stands
                    if (phase_reg == PH_WRITE && slot_reg == gi)
                        dm_dn_reg[gi] <= pcm_sr_reg;
                    // Unassigned interface slots must not overwrite a live location
                    if (phase_reg == PH_WRITE && up_ent.slot == gi && up_ent.code != CC_UNASSIGNED)
                        dm_up_reg[gi] <= up_sr_reg;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            cmd_done <= 1'b0;
        else
            cmd_done <= done_next;
    end

    // Checks
    property p_tri_write;
        @(posedge clk) disable iff (sys_rst)
        is_tri |=> tri_reg[$past(host_cmd.addr[SLOT_W-1:0])] == $past(host_cmd.data[3:0]);
    endproperty
    a_tri_write: assert property (p_tri_write) else $error("tristate field not written");
    property p_done;
        @(posedge clk) disable iff (sys_rst)
        (is_conn || is_tri) |=> cmd_done;
    endproperty
    a_done: assert property (p_done) else $error("command not acknowledged");
    property p_cfi_oe;
        @(posedge clk) disable iff (sys_rst)
        (dn_ent.code == CC_UNASSIGNED) |=> !cfi_tx_oe;
    endproperty
    a_cfi_oe: assert property (p_cfi_oe) else $error("output enabled for unassigned code");
    property p_window;
        @(posedge clk) disable iff (sys_rst)
        (phase_reg == PH_WRITE) |-> (bit_reg == WR_WINDOW);
    endproperty
    a_window: assert property (p_window) else $error("write outside window");
    property p_conn_up;
        @(posedge clk) disable iff (sys_rst)
        (is_conn && up_sel) |=> cm_up_reg[$past(host_cmd.addr[SLOT_W-1:0])].dir == $past(host_cmd.data[DIR_BIT]);
    endproperty
    a_conn_up: assert property (p_conn_up) else $error("upstream entry not written");
    property p_conn_dn;
        @(posedge clk) disable iff (sys_rst)
        (is_conn && !up_sel) |=> cm_dn_reg[$past(host_cmd.addr[SLOT_W-1:0])].code == $past(host_cmd.ctrl[3:0]);
    endproperty
    a_conn_dn: assert property (p_conn_dn) else $error("downstream entry not written");
    property p_serial;
        @(posedge clk) disable iff (sys_rst)
        (phase_next != PH_READ) |=> pcm_out_reg == {$past(pcm_out_reg[6:0]), 1'b0};
    endproperty
    a_serial: assert property (p_serial) else $error("transmit shift broken");
    property p_slot_adv;
        @(posedge clk) disable iff (sys_rst)
        (bit_reg == LAST_BIT && !(fs_s && !fs_d_reg)) |=> slot_reg == $past(slot_reg) + 5'h01;
    endproperty
    a_slot_adv: assert property (p_slot_adv) else $error("slot counter stuck");
endmodule

// File: hdl/tsloop_pkg.sv
// Shared constants and carriers for the loop-capable time-slot switch
package tsloop_pkg;
    localparam int NUM_SLOTS = 32;
    localparam int SLOT_W = 5;
    localparam int BITS_PER_SLOT = 8;
    localparam int BIT_CNT_W = 3;
    localparam logic [2:0] LAST_BIT = 3'h7;
    // Access windows inside a slot, in bit periods
    localparam logic [2:0] WR_WINDOW = 3'h7;
    localparam logic [2:0] RD_WINDOW = 3'h0;
    // Command codes written to the access control register
    localparam logic [7:0] CMD_TRISTATE = 8'h60;
    localparam logic [3:0] CMD_CONN_HI = 4'h7;
    localparam logic [3:0] CC_UNASSIGNED = 4'h0;
    localparam logic [3:0] CC_FULL_64K = 4'h1;
    localparam logic [3:0] CC_MAX = 4'h7;
    localparam logic [7:0] TRI_ALL_LOW_Z = 8'h0F;
    localparam logic [7:0] TRI_ALL_HIGH_Z = 8'h00;
    localparam int DIR_BIT = 7;

    // Control memory entry: pointer direction, slot, connection code
    typedef struct packed {
        logic dir;
        logic [SLOT_W-1:0] slot;
        logic [3:0] code;
    } cm_entry_s;

    // Host command bundle
    typedef struct packed {
        logic [7:0] data;
        logic [7:0] addr;
        logic [7:0] ctrl;
    } host_cmd_s;

    // One-hot access phase
    typedef enum logic [2:0] {
        PH_IDLE = 3'b001,
        PH_WRITE = 3'b010,
        PH_READ = 3'b100
    } phase_e;
endpackage

// File: verification/serial_far_end.sv
// Far-end serial highways: frame marker and one programmable byte per line
`timescale 1ns/1ps
module serial_far_end
    import tsloop_pkg::*;
(
    input wire logic clk,
    input wire logic [SLOT_W-1:0] pcm_slot,
    input wire logic [7:0] pcm_byte,
    input wire logic [SLOT_W-1:0] cfi_slot,
    input wire logic [7:0] cfi_byte,
    output logic frame_sync,
    output logic pcm_rx,
    output logic cfi_rx
);
    logic [7:0] pos_reg = 8'h00;
    initial frame_sync = 1'b0;
    initial pcm_rx = 1'b0;
    initial cfi_rx = 1'b0;
    // Lines move on the falling edge; other slots carry zero bytes, MSB first
    always @(negedge clk)
    begin
        frame_sync <= (pos_reg < 8'h04);
        pcm_rx <= (pos_reg[7:3] == pcm_slot) ? pcm_byte[3'h7 - pos_reg[2:0]] : 1'b0;
        cfi_rx <= (pos_reg[7:3] == cfi_slot) ? cfi_byte[3'h7 - pos_reg[2:0]] : 1'b0;
        pos_reg <= pos_reg + 8'h01;
    end
endmodule

// File: verification/tb.sv
// Self-checking bench: host commands, loops, tristate field and frame delay
`timescale 1ns/1ps
module tb
    import tsloop_pkg::*;
;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic frame_sync, pcm_rx, cfi_rx, pcm_tx, pcm_tx_oe, cfi_tx, cfi_tx_oe, cmd_done;
    host_cmd_s host_cmd = '0;
    logic host_cmd_stb = 1'b0;
    logic [SLOT_W-1:0] slot_index;
    logic [SLOT_W-1:0] pcm_slot = 5'h0D;
    logic [SLOT_W-1:0] cfi_slot = 5'h04;
    logic [7:0] pcm_byte = 8'hA5;
    logic [7:0] cfi_byte = 8'hC3;
    int n_mismatch = 0;
    int comparisons = 0;
    int cycles = 0;
    int hits, oe_cnt;
    logic [SLOT_W-1:0] slot_seen;

    always #50 clk = ~clk;

    serial_far_end far_end (.clk(clk), .pcm_slot(pcm_slot), .pcm_byte(pcm_byte), .cfi_slot(cfi_slot),
        .cfi_byte(cfi_byte), .frame_sync(frame_sync), .pcm_rx(pcm_rx), .cfi_rx(cfi_rx));

    timeslot_loop_switch_delay #(.SLOTS(NUM_SLOTS)) DUT (.clk(clk), .sys_rst(sys_rst),
        .frame_sync(frame_sync), .pcm_rx(pcm_rx), .cfi_rx(cfi_rx), .host_cmd(host_cmd),
        .host_cmd_stb(host_cmd_stb), .pcm_tx(pcm_tx), .pcm_tx_oe(pcm_tx_oe), .cfi_tx(cfi_tx),
        .cfi_tx_oe(cfi_tx_oe), .slot_index(slot_index), .cmd_done(cmd_done));

    task automatic end_of_test();
        $display("Comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // Called on a falling edge; one command per cycle, strobe stays high back to back
    task automatic send(input logic [7:0] d, input logic [7:0] a, input logic [7:0] c, input logic done);
        host_cmd = '{data: d, addr: a, ctrl: c};
        host_cmd_stb = 1'b1;
        @(negedge clk);
        check("cmd_done", {31'h0, cmd_done}, {31'h0, done});
    endtask

    task automatic idle();
        host_cmd_stb = 1'b0;
        @(negedge clk);
        check("cmd_done_len", {31'h0, cmd_done}, 32'h0);
    endtask

    task automatic frames(input int n);
        repeat (n * 256) @(negedge clk);
    endtask

    // Slides an 8-bit window over a line; a hit needs the enable high all 8 bits
    task automatic scan(input bit on_pcm, input logic [7:0] pat, output int hit, output int oe);
        logic [7:0] sr;
        logic [7:0] oe_sr;
        sr = 8'h00;
        oe_sr = 8'h00;
        hit = 0;
        oe = 0;
        repeat (264)
        begin
            @(negedge clk);
            sr = {sr[6:0], on_pcm ? pcm_tx : cfi_tx};
            oe_sr = {oe_sr[6:0], on_pcm ? pcm_tx_oe : cfi_tx_oe};
            if (oe_sr[0] === 1'b1)
                oe++;
            if (sr === pat && oe_sr === 8'hFF)
                hit++;
        end
    endtask

    // Hang guard, about twice the planned run
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 10000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end

    initial
    begin
        repeat (12) @(negedge clk);
        // Quiet outputs while reset holds
        check("idle outputs", {22'h0, slot_index, pcm_tx, pcm_tx_oe, cfi_tx, cfi_tx_oe, cmd_done}, 32'h0);
        sys_rst = 1'b0;
        // Refused control codes give no completion
        send(8'h00, 8'h1F, 8'h55, 1'b0);
        send(8'h00, 8'h1F, 8'h78, 1'b0);
        idle();
        // All connection codes accepted back to back, ending unassigned
        for (int c = 7; c >= 0; c--)
            send(8'h00, 8'h1F, {CMD_CONN_HI, 4'(c)}, 1'b1);
        idle();
        // Transparent first connection: PCM slot 13 to interface slot 4
        send(8'h0D, 8'h04, 8'h71, 1'b1);
        idle();
        frames(2);
        scan(1'b0, 8'hA5, hits, oe_cnt);
        check("pcm to cfi", {31'h0, hits != 0}, 32'h1);
        // Slot counter steps once per slot of eight bit periods
        slot_seen = slot_index;
        repeat (BITS_PER_SLOT) @(negedge clk);
        check("slot_index", {27'h0, slot_index}, {27'h0, SLOT_W'(slot_seen + 5'h01)});
        // Loop back upstream with leading 0; external interface byte differs
        send(8'h05, 8'h84, 8'h71, 1'b1);
        send(TRI_ALL_LOW_Z, 8'h85, CMD_TRISTATE, 1'b1);
        idle();
        frames(2);
        scan(1'b1, 8'hA5, hits, oe_cnt);
        check("pcm loop", {31'h0, hits != 0}, 32'h1);
        // Non-transparent: interface output stays disabled, loop still runs
        send(8'h0D, 8'h04, 8'h70, 1'b1);
        idle();
        frames(2);
        scan(1'b0, 8'hA5, hits, oe_cnt);
        check("cfi oe off", 32'(oe_cnt), 32'h0);
        scan(1'b1, 8'hA5, hits, oe_cnt);
        check("loop kept", {31'h0, hits != 0}, 32'h1);
        // New byte must be out by frame N+2 and old byte gone
        pcm_byte = 8'h5A;
        frames(3);
        scan(1'b1, 8'h5A, hits, oe_cnt);
        check("new byte", {31'h0, hits != 0}, 32'h1);
        scan(1'b1, 8'hA5, hits, oe_cnt);
        check("old byte", 32'(hits), 32'h0);
        // All bit pairs to high impedance
        send(TRI_ALL_HIGH_Z, 8'h85, CMD_TRISTATE, 1'b1);
        idle();
        frames(1);
        scan(1'b1, 8'h5A, hits, oe_cnt);
        check("pcm oe off", 32'(oe_cnt), 32'h0);
        // Interface loop through upstream PCM slot 0, same pointer twice
        cfi_slot = 5'h14;
        cfi_byte = 8'h3C;
        send(8'h80, 8'h94, 8'h71, 1'b1);
        send(8'h80, 8'h1B, 8'h71, 1'b1);
        idle();
        frames(2);
        scan(1'b0, 8'h3C, hits, oe_cnt);
        check("cfi loop", {31'h0, hits != 0}, 32'h1);
        end_of_test();
    end
endmodule
